/* File: logic/sac_clk_div.sv */
`timescale 1ns/1ps
// Conversion clock as a one-cycle enable: system clock divided by 2**divider
module sac_clk_div (
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic [2:0] divider,
	output logic            tick
);
	typedef struct packed {
		logic [6:0] cnt;
	} sac_div_s;

	sac_div_s   q_r;
	sac_div_s   q_nxt;
	logic [6:0] mask;

	// Mask of low counter bits that must all be set for a tick
	// power-of-two divide
	assign mask = 7'((8'h01 << divider) - 8'h01);
	assign tick = ((q_r.cnt & mask) == mask);

	// Free running counter; a divider change only shifts phase
	always_comb begin
		q_nxt     = q_r;
		q_nxt.cnt = q_r.cnt + 7'h01;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end
endmodule : sac_clk_div

/* File: logic/sac_control.sv */
`timescale 1ns/1ps
module sac_control (
	input  wire logic        clk,
	input  wire logic        reset_n,
	// Avalon-MM slave
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// Analog front end
	input  wire logic        comparator_high,
	output logic             analog_power_en,
	output logic [1:0]       reference_select,
	output logic [1:0]       amp_gain_select,
	output logic             amp_enable,
	output logic             amp_input_select,
	output logic             bandgap_enable,
	output logic             bandgap_output_oe,
	output logic [3:0]       input_source_select,
	output logic             external_path_en,
	output logic [15:0]      channel_connect,
	output logic             sample_en,
	output logic [11:0]      sar_dac_code,
	// Shared pin control
	output logic [15:0]      pin_analog_mode,
	output logic [15:0]      pullup_disable,
	output logic [15:0]      direction_override,
	// Interrupt request
	output logic             converter_irq
);
	typedef struct packed {
		sac_pkg::sac_state_e st;
		logic        start;
		logic        power_on;
		logic        fmt;
		logic [3:0]  chan;
		logic [3:0]  src;
		logic [2:0]  ckdiv;
		logic        amp_en;
		logic        amp_in;
		logic [1:0]  ref_sel;
		logic [1:0]  gain;
		logic        bg_en;
		logic        gie;
		logic        cie;
		logic        flag;
		logic        busy;
		logic [7:0]  res_hi;
		logic [7:0]  res_lo;
		logic [15:0] pinsel;
		logic [3:0]  cnt;
		logic        ack;
		logic [31:0] rdata;
	} sac_ctl_s;

	sac_ctl_s    q_r;
	sac_ctl_s    q_nxt;
	logic        conv_tick;
	logic        sar_load;
	logic        sar_step;
	logic [11:0] result;
	logic        ext_sel;
	logic        wr_go;

	// True when the source code routes an external pin to the converter
	function automatic logic is_external(input logic [3:0] code);
		is_external = (code == 4'h0) || (code == 4'h4) || (code[3:2] == 2'b11);
	endfunction : is_external

	// Address decode shared by read and write paths
	function automatic logic is_reg(input logic [4:0] a, input logic [4:0] ofs);
		is_reg = (a == ofs);
	endfunction : is_reg

	sac_clk_div u_div (
		.clk     (clk),
		.reset_n (reset_n),
		.divider (q_r.ckdiv),
		.tick    (conv_tick)
	);

	sac_sar_engine u_sar (
		.clk             (clk),
		.reset_n         (reset_n),
		.load            (sar_load),
		.step            (sar_step),
		.comparator_high (comparator_high),
		.dac_code        (result)
	);

	// Bus answers after one wait cycle so read data comes from a flop
	assign avs_waitrequest = (avs_read | avs_write) & ~q_r.ack;
	assign avs_readdata    = q_r.rdata;
	assign wr_go           = avs_write & q_r.ack;

	// Sequencer strobes toward the SAR engine
	// count begins on the first conversion clock after start falls
	assign sar_load  = (q_r.st == sac_pkg::ST_ARMED) & conv_tick;
	// last twelve cycles decide one bit each
	assign sar_step  = (q_r.st == sac_pkg::ST_RUN) & conv_tick
		& (q_r.cnt >= sac_pkg::SAMPLE_CYCLES);
	assign sample_en = (q_r.st == sac_pkg::ST_RUN) & (q_r.cnt < sac_pkg::SAMPLE_CYCLES);
	assign sar_dac_code = result;

	// Analog controls follow the registers directly, except the gated external path
	// power gate
	assign analog_power_en     = q_r.power_on;
	// reference choice, 1x means amplifier output
	assign reference_select    = q_r.ref_sel;
	assign amp_gain_select     = q_r.gain;
	assign amp_enable          = q_r.amp_en;
	assign amp_input_select    = q_r.amp_in;
	assign bandgap_enable      = q_r.bg_en;
	assign bandgap_output_oe   = q_r.bg_en;
	// internal codes pass to the analog mux as is
	assign input_source_select = q_r.src;
	assign ext_sel             = is_external(q_r.src);
	// external path off for internal sources
	assign external_path_en    = ext_sel & q_r.power_on;
	assign converter_irq       = q_r.flag & q_r.gie & q_r.cie;

	// Per-pin switches; a pin connects only if both its mode and the channel agree
	generate
		for (genvar i = 0; i < 16; i++) begin : g_pin
			// analog mode drops digital functions and pull-high
			assign pin_analog_mode[i]    = q_r.pinsel[i];
			assign pullup_disable[i]     = q_r.pinsel[i];
			assign direction_override[i] = q_r.pinsel[i];
			// channel field picks one of sixteen pins
			assign channel_connect[i]    = external_path_en & q_r.pinsel[i]
				& (q_r.chan == 4'(i));
		end
	endgenerate

	// Next state: bus access, register writes and the conversion sequence
	always_comb begin
		q_nxt     = q_r;
		q_nxt.ack = (avs_read | avs_write) & ~q_r.ack;

		// Read data captured in the wait cycle, stands at the answering edge
		q_nxt.rdata = 32'h0000_0000;
		if (avs_read & ~q_r.ack) begin
			unique case (1'b1)
				is_reg(avs_address, sac_pkg::OFS_CONTROL_0): begin
					q_nxt.rdata[sac_pkg::C0_START]     = q_r.start;
					q_nxt.rdata[sac_pkg::C0_BUSY]      = q_r.busy;
					q_nxt.rdata[sac_pkg::C0_POWER]     = q_r.power_on;
					q_nxt.rdata[sac_pkg::C0_FMT]       = q_r.fmt;
					q_nxt.rdata[sac_pkg::C0_CHAN +: 4] = q_r.chan;
				end
				is_reg(avs_address, sac_pkg::OFS_CONTROL_1): begin
					q_nxt.rdata[sac_pkg::C1_SRC +: 4]   = q_r.src;
					q_nxt.rdata[sac_pkg::C1_CKDIV +: 3] = q_r.ckdiv;
				end
				is_reg(avs_address, sac_pkg::OFS_CONTROL_2): begin
					q_nxt.rdata[sac_pkg::C2_AMP_EN]    = q_r.amp_en;
					q_nxt.rdata[sac_pkg::C2_AMP_IN]    = q_r.amp_in;
					q_nxt.rdata[sac_pkg::C2_REF +: 2]  = q_r.ref_sel;
					q_nxt.rdata[sac_pkg::C2_GAIN +: 2] = q_r.gain;
				end
				is_reg(avs_address, sac_pkg::OFS_BANDGAP): begin
					q_nxt.rdata[sac_pkg::BG_EN] = q_r.bg_en;
				end
				is_reg(avs_address, sac_pkg::OFS_RESULT_LOW): begin
					q_nxt.rdata[7:0] = q_r.res_lo;
				end
				is_reg(avs_address, sac_pkg::OFS_RESULT_HIGH): begin
					q_nxt.rdata[7:0] = q_r.res_hi;
				end
				is_reg(avs_address, sac_pkg::OFS_INT_CONTROL): begin
					q_nxt.rdata[sac_pkg::IC_GIE]  = q_r.gie;
					q_nxt.rdata[sac_pkg::IC_CIE]  = q_r.cie;
					q_nxt.rdata[sac_pkg::IC_FLAG] = q_r.flag;
				end
				is_reg(avs_address, sac_pkg::OFS_PIN_SELECT): begin
					q_nxt.rdata[15:0] = q_r.pinsel;
				end
				default: begin
					q_nxt.rdata = 32'h0000_0000;
				end
			endcase
		end

		// Register writes; only byte lanes that carry a field are honoured
		if (wr_go && avs_byteenable[0]) begin
			unique case (1'b1)
				is_reg(avs_address, sac_pkg::OFS_CONTROL_0): begin
					q_nxt.start    = avs_writedata[sac_pkg::C0_START];
					q_nxt.power_on = avs_writedata[sac_pkg::C0_POWER];
					q_nxt.fmt      = avs_writedata[sac_pkg::C0_FMT];
					q_nxt.chan     = avs_writedata[sac_pkg::C0_CHAN +: 4];
				end
				is_reg(avs_address, sac_pkg::OFS_CONTROL_1): begin
					q_nxt.src   = avs_writedata[sac_pkg::C1_SRC +: 4];
					q_nxt.ckdiv = avs_writedata[sac_pkg::C1_CKDIV +: 3];
				end
				is_reg(avs_address, sac_pkg::OFS_CONTROL_2): begin
					q_nxt.amp_en  = avs_writedata[sac_pkg::C2_AMP_EN];
					q_nxt.amp_in  = avs_writedata[sac_pkg::C2_AMP_IN];
					q_nxt.ref_sel = avs_writedata[sac_pkg::C2_REF +: 2];
					q_nxt.gain    = avs_writedata[sac_pkg::C2_GAIN +: 2];
				end
				is_reg(avs_address, sac_pkg::OFS_BANDGAP): begin
					q_nxt.bg_en = avs_writedata[sac_pkg::BG_EN];
				end
				is_reg(avs_address, sac_pkg::OFS_INT_CONTROL): begin
					q_nxt.gie  = avs_writedata[sac_pkg::IC_GIE];
					q_nxt.cie  = avs_writedata[sac_pkg::IC_CIE];
					q_nxt.flag = avs_writedata[sac_pkg::IC_FLAG];
				end
				is_reg(avs_address, sac_pkg::OFS_PIN_SELECT): begin
					q_nxt.pinsel[7:0] = avs_writedata[7:0];
				end
				default: begin
				end
			endcase
		end
		if (wr_go && avs_byteenable[1] && is_reg(avs_address, sac_pkg::OFS_PIN_SELECT)) begin
			q_nxt.pinsel[15:8] = avs_writedata[15:8];
		end

		// Conversion sequence
		unique case (q_r.st)
			sac_pkg::ST_IDLE: begin
				// falling start edge arms a conversion
				if (q_r.start && !q_nxt.start && q_nxt.power_on) begin
					q_nxt.st = sac_pkg::ST_ARMED;
				end
			end
			sac_pkg::ST_ARMED: begin
				if (conv_tick) begin
					// busy rises on this conversion clock
					q_nxt.st   = sac_pkg::ST_RUN;
					q_nxt.busy = 1'b1;
					q_nxt.cnt  = 4'h0;
				end
			end
			sac_pkg::ST_RUN: begin
				if (conv_tick) begin
					q_nxt.cnt = q_r.cnt + 4'h1;
					if (q_r.cnt == sac_pkg::LAST_CYCLE) begin
						q_nxt.st = sac_pkg::ST_FINISH;
					end
				end
			end
			sac_pkg::ST_FINISH: begin
				// SAR settles one system clock after the last step
				q_nxt.st   = sac_pkg::ST_IDLE;
				// busy drops together with results becoming valid
				q_nxt.busy = 1'b0;
				if (q_r.fmt) begin
					q_nxt.res_hi = {4'h0, result[11:8]};
					q_nxt.res_lo = result[7:0];
				end else begin
					q_nxt.res_hi = result[11:4];
					q_nxt.res_lo = {result[3:0], 4'h0};
				end
				// completion sets the flag; set wins over a same-cycle clear
				q_nxt.flag = 1'b1;
			end
			default: begin
				q_nxt.st = sac_pkg::ST_IDLE;
			end
		endcase

		// start held high, or power off, keeps the converter in reset
		if (q_nxt.start || !q_nxt.power_on) begin
			q_nxt.busy = 1'b0;
			if (q_r.st != sac_pkg::ST_FINISH) begin
				q_nxt.st = sac_pkg::ST_IDLE;
			end
		end
	end

	// results change only in the finish state above
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			q_r        <= '0;
			q_r.st     <= sac_pkg::ST_IDLE;
			q_r.res_hi <= sac_pkg::RST_BYTE;
			q_r.res_lo <= sac_pkg::RST_BYTE;
			q_r.pinsel <= sac_pkg::RST_PINS;
		end else begin
			q_r <= q_nxt;
		end
	end
endmodule : sac_control

/* File: logic/sac_sar_engine.sv */
`timescale 1ns/1ps
// Successive approximation register: one bit decided per step
module sac_sar_engine (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        load,
	input  wire logic        step,
	input  wire logic        comparator_high,
	output logic [11:0]      dac_code
);
	typedef struct packed {
		logic [11:0] code;
		logic [11:0] trial;
	} sac_sar_s;

	sac_sar_s q_r;
	sac_sar_s q_nxt;

	assign dac_code = q_r.code;

	// Keep the trial bit if the input is above the DAC, then try the next one
	always_comb begin
		q_nxt = q_r;
		if (load) begin
			q_nxt.code  = 12'h800;
			q_nxt.trial = 12'h800;
		end else if (step) begin
			q_nxt.code  = (comparator_high ? q_r.code : (q_r.code & ~q_r.trial))
				| (q_r.trial >> 1);
			q_nxt.trial = q_r.trial >> 1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end
endmodule : sac_sar_engine

/* File: pkg/sac_pkg.sv */
package sac_pkg;

	// Register byte offsets on the word-aligned bus
	localparam logic [4:0] OFS_CONTROL_0   = 5'h00;
	localparam logic [4:0] OFS_CONTROL_1   = 5'h04;
	localparam logic [4:0] OFS_CONTROL_2   = 5'h08;
	localparam logic [4:0] OFS_BANDGAP     = 5'h0c;
	localparam logic [4:0] OFS_RESULT_LOW  = 5'h10;
	localparam logic [4:0] OFS_RESULT_HIGH = 5'h14;
	localparam logic [4:0] OFS_INT_CONTROL = 5'h18;
	localparam logic [4:0] OFS_PIN_SELECT  = 5'h1c;

	// Field positions in converter_control_0
	localparam int C0_START = 7;
	localparam int C0_BUSY  = 6;
	localparam int C0_POWER = 5;
	localparam int C0_FMT   = 4;
	localparam int C0_CHAN  = 0;
	// Field positions in converter_control_1
	localparam int C1_SRC   = 4;
	localparam int C1_CKDIV = 0;
	// Field positions in converter_control_2
	localparam int C2_AMP_EN = 7;
	localparam int C2_AMP_IN = 4;
	localparam int C2_REF    = 2;
	localparam int C2_GAIN   = 0;
	// Field positions in bandgap_control and interrupt control
	localparam int BG_EN     = 0;
	localparam int IC_GIE    = 0;
	localparam int IC_CIE    = 1;
	localparam int IC_FLAG   = 2;

	// Reset values
	localparam logic [7:0]  RST_BYTE = 8'h00;
	localparam logic [15:0] RST_PINS = 16'h0000;

	// Conversion timing in conversion-clock cycles
	localparam logic [3:0] SAMPLE_CYCLES  = 4'h4;
	localparam logic [3:0] CONVERT_CYCLES = 4'hc;
	localparam logic [3:0] LAST_CYCLE     = 4'hf;
	localparam int         RESULT_BITS    = 12;

	// Reference select codes
	localparam logic [1:0] REF_SUPPLY   = 2'h0;
	localparam logic [1:0] REF_EXTERNAL = 2'h1;

	// Sequencer states
	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0001,
		ST_ARMED  = 4'b0010,
		ST_RUN    = 4'b0100,
		ST_FINISH = 4'b1000
	} sac_state_e;

endpackage : sac_pkg

/* File: testbench/sac_analog_model.sv */
`timescale 1ns/1ps
// Analog front end: sample-and-hold plus an ideal comparator
module sac_analog_model (
	input wire logic        clk,
	input wire logic        analog_power_en,
	input wire logic        external_path_en,
	input wire logic [3:0]  input_source_select,
	input wire logic        sample_en,
	input wire logic [11:0] sar_dac_code,
	input wire logic [11:0] ext_level,
	output logic            comparator_high
);
	logic [11:0] held;

	always @(posedge clk) begin
		if (sample_en)
			held <= external_path_en ? ext_level : 12'hfff >> (input_source_select[1:0] - 2'h1);
	end

	assign comparator_high = analog_power_en && (held >= sar_dac_code);
endmodule : sac_analog_model

/* File: testbench/sac_properties.sv */
`timescale 1ns/1ps
// Port-level checks of the converter control block
module sac_properties (
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        analog_power_en,
	input wire logic        bandgap_enable,
	input wire logic        bandgap_output_oe,
	input wire logic [3:0]  input_source_select,
	input wire logic        external_path_en,
	input wire logic [15:0] channel_connect,
	input wire logic        sample_en,
	input wire logic [15:0] pin_analog_mode,
	input wire logic [15:0] pullup_disable,
	input wire logic [15:0] direction_override
);
	logic ext_code;

	// Source codes that leave the external channel in use
	assign ext_code = (input_source_select == 4'h0) || (input_source_select == 4'h4) ||
		(input_source_select[3:2] == 2'h3);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	sequence s_req_wait;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_sample;
		sample_en [*4];
	endsequence

	AST_BUS_WAIT: assert property (s_req_wait |=> !avs_waitrequest)
		else $error("wait state longer than one cycle");
	AST_RD_IDLE: assert property (!(avs_read && !avs_waitrequest) |-> avs_readdata == 32'h0)
		else $error("read data outside the answer cycle");
	AST_POWER_GATE: assert property (!analog_power_en |-> !external_path_en)
		else $error("input path live while powered down");
	AST_INT_SRC: assert property (!ext_code |-> !external_path_en && channel_connect == 16'h0)
		else $error("external path on with internal source");
	AST_EXT_SRC: assert property (ext_code && analog_power_en |-> external_path_en &&
		$onehot0(channel_connect) && (channel_connect & ~pin_analog_mode) == 16'h0)
		else $error("external channel routing wrong");
	AST_BG_HIZ: assert property (bandgap_output_oe == bandgap_enable)
		else $error("bandgap output drive mismatch");
	AST_PIN_OVR: assert property (pullup_disable == pin_analog_mode &&
		direction_override == pin_analog_mode)
		else $error("pin override mismatch");
	AST_SAMPLE4: assert property ($rose(sample_en) |-> s_sample)
		else $error("sampling shorter than four clocks");
endmodule : sac_properties

bind sac_control sac_properties u_props (.clk, .reset_n, .avs_read, .avs_write, .avs_readdata,
	.avs_waitrequest, .analog_power_en, .bandgap_enable, .bandgap_output_oe,
	.input_source_select, .external_path_en, .channel_connect, .sample_en,
	.pin_analog_mode, .pullup_disable, .direction_override);

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
// Self-checking bench for the converter control block
module tb_top;
	localparam logic [4:0] A0 = sac_pkg::OFS_CONTROL_0;
	localparam logic [4:0] A1 = sac_pkg::OFS_CONTROL_1;
	localparam logic [4:0] A2 = sac_pkg::OFS_CONTROL_2;
	localparam logic [4:0] AB = sac_pkg::OFS_BANDGAP;
	localparam logic [4:0] AI = sac_pkg::OFS_INT_CONTROL;
	localparam logic [4:0] AP = sac_pkg::OFS_PIN_SELECT;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, q;
	logic [11:0] sar_dac_code;
	logic [11:0] ext_level = 12'h000;
	logic [15:0] channel_connect, pin_analog_mode, pullup_disable, direction_override;
	logic [3:0]  input_source_select;
	logic [1:0]  reference_select, amp_gain_select;
	logic        avs_waitrequest, comparator_high, analog_power_en, amp_enable;
	logic        amp_input_select, bandgap_enable, bandgap_output_oe, external_path_en;
	logic        sample_en, converter_irq;
	int          n_errors = 0;
	int          compares = 0;
	int          cyc = 0;
	int          n_samp = 0;

	sac_control dut (.clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .comparator_high,
		.analog_power_en, .reference_select, .amp_gain_select, .amp_enable, .amp_input_select,
		.bandgap_enable, .bandgap_output_oe, .input_source_select, .external_path_en,
		.channel_connect, .sample_en, .sar_dac_code, .pin_analog_mode, .pullup_disable,
		.direction_override, .converter_irq);
	sac_analog_model u_model (.clk, .analog_power_en, .external_path_en, .input_source_select,
		.sample_en, .sar_dac_code, .ext_level, .comparator_high);

	always #2.5 clk = ~clk;

	// Cycle ceiling against hangs; sampling clocks counted alongside
	always @(posedge clk) begin
		cyc++;
		if (sample_en === 1'b1)
			n_samp++;
		if (cyc == 20000) begin
			n_errors++;
			end_of_test();
		end
	end

	task automatic end_of_test;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// One Avalon transfer; extra idle edge so strobes never toggle twice in a step
	task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
		avs_address <= a;
		avs_writedata <= {16'h0, d};
		avs_write <= w;
		avs_read <= !w;
		// Seen before the edge updates the block; only the watchdog ends a stuck wait
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask : bus

	task automatic t_reset;
		for (int i = 0; i < 8; i++) begin
			bus(1'b0, 5'(i * 4), 16'h0);
			chk(q, 32'h0);
		end
		bus(1'b1, 5'h02, 16'h00ff);
		bus(1'b0, 5'h02, 16'h0);
		chk(q, 32'h0);
		bus(1'b0, A0, 16'h0);
		chk(q, 32'h0);
	endtask : t_reset

	task automatic t_static;
		logic [7:0] v;
		for (int i = 0; i < 16; i++) begin
			v = {i[0], 2'h0, i[1], i[3:0]};
			bus(1'b1, A2, {8'h0, v});
			chk({amp_enable, amp_input_select, reference_select, amp_gain_select},
				{i[0], i[1], i[3:0]});
			bus(1'b0, A2, 16'h0);
			chk(q, {24'h0, v});
		end
		bus(1'b1, AB, 16'h00ff);
		chk({bandgap_enable, bandgap_output_oe}, 32'h3);
		bus(1'b0, AB, 16'h0);
		chk(q, 32'h1);
		bus(1'b1, AB, 16'h00fe);
		chk({bandgap_enable, bandgap_output_oe}, 32'h0);
	endtask : t_static

	task automatic t_pins;
		logic ext;
		bus(1'b1, AP, 16'h0a28);
		chk({pin_analog_mode, pullup_disable}, 32'h0a280a28);
		chk(direction_override, 32'h0a28);
		bus(1'b1, A0, 16'h0025);
		for (int s = 0; s < 16; s++) begin
			ext = (s == 0) || (s == 4) || (s >= 12);
			bus(1'b1, A1, {8'h0, s[3:0], 4'h0});
			chk(external_path_en, ext);
			chk(channel_connect, ext ? 32'h20 : 32'h0);
		end
		bus(1'b1, A0, 16'h0026);
		chk(channel_connect, 32'h0);
		bus(1'b1, A0, 16'h0005);
		chk({analog_power_en, external_path_en}, 32'h0);
	endtask : t_pins

	task automatic t_conv(input logic [2:0] dv, input logic [3:0] src, input logic fmt,
		input logic [11:0] lvl, input logic [11:0] res);
		int n;
		ext_level <= lvl;
		if (src == 4'h2)
			bus(1'b1, AP, 16'h0a20);
		// amplifier off, its output is not used here
		bus(1'b1, A2, 16'h0000);
		bus(1'b1, A1, {8'h0, src, 1'b0, dv});
		bus(1'b1, A0, {8'h0, 3'h1, fmt, 4'h3});
		repeat (8) @(posedge clk);
		bus(1'b1, AI, 16'h0003);
		n_samp = 0;
		bus(1'b1, A0, {8'h0, 3'h5, fmt, 4'h3});
		bus(1'b1, A0, {8'h0, 3'h1, fmt, 4'h3});
		n = 0;
		do begin
			bus(1'b0, A0, 16'h0);
			n++;
		end while (q[6] !== 1'b1 && n < 8);
		chk(q[6], 32'h1);
		n = 0;
		do begin
			bus(1'b0, A0, 16'h0);
			n++;
		end while (q[6] !== 1'b0 && n < 300);
		chk(q[6], 32'h0);
		chk(n_samp, 32'h4 << dv);
		ext_level <= ~lvl;
		repeat (2) begin
			bus(1'b0, sac_pkg::OFS_RESULT_HIGH, 16'h0);
			chk(q, fmt ? {28'h0, res[11:8]} : {24'h0, res[11:4]});
		end
		bus(1'b0, sac_pkg::OFS_RESULT_LOW, 16'h0);
		chk(q, fmt ? {24'h0, res[7:0]} : {24'h0, res[3:0], 4'h0});
		chk(converter_irq, 32'h1);
		bus(1'b0, AI, 16'h0);
		chk(q, 32'h7);
	endtask : t_conv

	task automatic t_abort;
		bus(1'b1, AI, 16'h0005);
		chk(converter_irq, 32'h0);
		bus(1'b1, AI, 16'h0003);
		bus(1'b1, A0, 16'h00a3);
		repeat (6) begin
			bus(1'b0, A0, 16'h0);
			chk(q[6], 32'h0);
		end
		chk(converter_irq, 32'h0);
		bus(1'b0, sac_pkg::OFS_RESULT_HIGH, 16'h0);
		chk(q, 32'h7f);
		bus(1'b1, A0, 16'h0003);
		chk(analog_power_en, 32'h0);
	endtask : t_abort

	// Main sequence: reset for four cycles, then the scenarios
	initial begin
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		t_reset();
		t_static();
		t_pins();
		t_conv(3'h0, 4'h0, 1'b0, 12'h5a3, 12'h5a3);
		t_conv(3'h2, 4'hc, 1'b1, 12'h9c6, 12'h9c6);
		t_conv(3'h1, 4'h2, 1'b0, 12'h000, 12'h7ff);
		t_abort();
		end_of_test();
	end
endmodule : tb_top
